// ### standby_power_control.sv
// standby power controller: sleep, software standby, module standby
// assumes AXI4-Lite from the CPU side, a watchdog that reports overflow,
// and external pins already synchronous to clk
//
// Behaviour
// R1 - reset pin low in standby restarts oscillator and clocks whole chip
// R2 - outside party holds reset pin low until oscillator is stable
// R3 - reset pin returning high starts CPU reset exception handling
// R4 - interrupt edge wakes oscillator only when wake enable is one
// R5 - during interrupt settling only the watchdog gets a clock
// R6 - watchdog overflow ends settling: whole chip clocked, interrupt handling
// R7 - software sets waking interrupt priority above CPU mask beforehand
// R8 - software picks watchdog period longer than oscillator settling
// R9 - falling or both edge: pin high at entry, low at resume
// R10 - rising edge: pin low at entry, high at resume
// R11 - falling or both edge wakes on fall; rising wakes on rise
// R12 - software never uses low level detection for wake
// R13 - stop bit one halts module at end of bus cycle
// R14 - stop bit zero restarts module at end of bus cycle
// R15 - module in standby has its internal state initialised
// R16 - serial, timer and converter modules start in module standby
// R17 - register access to a stopped module has no effect
// R18 - float select zero keeps every pin state during standby
// R19 - software disables module interrupts before stopping it
// R20 - only the CPU writes the module stop registers
// R21 - transfer controller makes no data access during sleep
// R22 - sleep with deep select stops CPU, peripherals, oscillator
// R23 - sleep without deep select halts only the CPU
// R24 - each stop bit drives its own clock gate and access block
`include "standby_params.svh"
module standby_power_control
  import standby_pkg::*;
#(
  parameter int PINS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  // axi4-lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and neighbours
  input wire logic hard_init_pin_n,
  input wire logic [PINS-1:0] irq_pin,
  input wire logic cpu_irq,
  input wire logic wdt_overflow,
  input wire logic bus_cycle_end,
  // clocking and cpu control
  output logic osc_en,
  output logic wdt_clk_en,
  output logic chip_clk_en,
  output logic cpu_halt,
  output logic cpu_reset_start,
  output logic irq_exc_start,
  output logic [2:0] watchdog_period_select,
  output logic port_hold,
  output logic port_float,
  // gated peripherals
  output logic [31:0] periph_clk_en,
  output logic [31:0] periph_init,
  output logic [31:0] periph_acc_en
);

  // ====================
  // registers
  logic [7:0] standby_ctrl;
  logic [7:0] edge_select;
  logic [15:0] module_stop_ctrl_a;
  logic [15:0] module_stop_ctrl_b;
  pwr_state_t state;
  pwr_state_t next_state;
  logic wake;
  logic sleep_cmd;
  logic init_low;
  logic init_low_d;

  // ====================
  // axi write path
  logic aw_full;
  logic w_full;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit;

  // either channel may arrive first; each is held until the other comes
  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full & ~s_axi_bvalid;
  assign do_write = aw_full & w_full & ~s_axi_bvalid;

  // address capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full <= 1'b0;
      aw_addr <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  // data capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end
  end

  // word decode; status is read only and refuses writes
  always_comb begin
    case ({aw_addr[5:2], 2'b00})
      `OFS_STANDBY_CTRL: wr_hit = 1'b1;
      `OFS_EDGE_SELECT: wr_hit = 1'b1;
      `OFS_STOP_A: wr_hit = 1'b1;
      `OFS_STOP_B: wr_hit = 1'b1;
      `OFS_COMMAND: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response one cycle after both halves are held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ====================
  // control registers
  logic wr_ctrl;
  logic wr_edge;
  logic wr_stop_a;
  logic wr_stop_b;
  assign wr_ctrl = do_write & ({aw_addr[5:2], 2'b00} == `OFS_STANDBY_CTRL);
  assign wr_edge = do_write & ({aw_addr[5:2], 2'b00} == `OFS_EDGE_SELECT);
  assign wr_stop_a = do_write & ({aw_addr[5:2], 2'b00} == `OFS_STOP_A);
  assign wr_stop_b = do_write & ({aw_addr[5:2], 2'b00} == `OFS_STOP_B);

  // standby control byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      standby_ctrl <= `RST_STANDBY_CTRL;
    end else if (wr_ctrl && w_strb[0]) begin
      standby_ctrl <= w_data[7:0];
    end
  end

  // per-pin wake edge mode, two bits a pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_select <= `RST_EDGE_SELECT;
    end else if (wr_edge && w_strb[0]) begin
      edge_select <= w_data[7:0];
    end
  end

  // stop registers; serial, timer and converter bits reset to one
  // the bus carries no master id, so cpu-only writing is left to software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      module_stop_ctrl_a <= `RST_STOP_A; // see R16
      module_stop_ctrl_b <= `RST_STOP_B; // see R16
    end else begin
      if (wr_stop_a && w_strb[0]) begin
        module_stop_ctrl_a[7:0] <= w_data[7:0];
      end
      if (wr_stop_a && w_strb[1]) begin
        module_stop_ctrl_a[15:8] <= w_data[15:8];
      end
      if (wr_stop_b && w_strb[0]) begin
        module_stop_ctrl_b[7:0] <= w_data[7:0];
      end
      if (wr_stop_b && w_strb[1]) begin
        module_stop_ctrl_b[15:8] <= w_data[15:8];
      end
    end
  end

  // a write of one to the command bit stands for the sleep instruction
  assign sleep_cmd = do_write & w_strb[0] & w_data[`BIT_SLEEP] &
                     ({aw_addr[5:2], 2'b00} == `OFS_COMMAND);

  assign watchdog_period_select = standby_ctrl[`PERIOD_MSB:0];

  // ====================
  // axi read path
  logic [31:0] rd_word;
  logic rd_hit;

  assign s_axi_arready = ~s_axi_rvalid;

  // read mux; unused upper bits read as zero
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      `OFS_STANDBY_CTRL: rd_word = {24'h000000, standby_ctrl};
      `OFS_EDGE_SELECT: rd_word = {24'h000000, edge_select};
      `OFS_STOP_A: rd_word = {16'h0000, module_stop_ctrl_a};
      `OFS_STOP_B: rd_word = {16'h0000, module_stop_ctrl_b};
      `OFS_STATUS: rd_word = {29'h00000000, state};
      `OFS_COMMAND: rd_word = 32'h0000_0000;
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read data registered, answered the cycle after the address is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ====================
  // wake edge detector
  wake_detect #(
    .PINS(PINS)
  ) u_wake (
    .clk(clk),
    .arst_n(arst_n),
    .armed(state == ST_STBY),
    .enable(standby_ctrl[`BIT_IRQ_WAKE]), // see R4
    .irq_edge_mode(edge_select[2*PINS-1:0]),
    .irq_pin(irq_pin),
    .wake(wake)
  );

  // ====================
  // power state machine
  assign init_low = ~hard_init_pin_n;

  // remembered pin level, for the release edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_low_d <= 1'b0;
    end else begin
      init_low_d <= init_low;
    end
  end

  // the reset pin outranks every other wake source
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (init_low) begin
          next_state = ST_INIT;
        end else if (sleep_cmd && standby_ctrl[`BIT_DEEP]) begin
          next_state = ST_STBY; // see R22
        end else if (sleep_cmd) begin
          next_state = ST_SLEEP; // see R23
        end
      end
      ST_SLEEP: begin
        if (init_low) begin
          next_state = ST_INIT;
        end else if (cpu_irq) begin
          next_state = ST_RUN;
        end
      end
      ST_STBY: begin
        if (init_low) begin
          next_state = ST_INIT; // see R1
        end else if (wake) begin
          next_state = ST_SETTLE; // see R4
        end
      end
      ST_SETTLE: begin
        if (init_low) begin
          next_state = ST_INIT;
        end else if (wdt_overflow) begin
          next_state = ST_RUN; // see R6
        end
      end
      ST_INIT: begin
        // held here while the pin is low, covering oscillator settling
        if (!init_low) begin
          next_state = ST_RUN; // see R3
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // exception starts as one-cycle pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_reset_start <= 1'b0;
      irq_exc_start <= 1'b0;
    end else begin
      cpu_reset_start <= (state == ST_INIT) & init_low_d & ~init_low; // see R3
      irq_exc_start <= (state == ST_SETTLE) & ~init_low & wdt_overflow; // see R6
    end
  end

  // clock and halt controls, registered so they glitch-free reach gates
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_en <= 1'b1;
      wdt_clk_en <= 1'b1;
      chip_clk_en <= 1'b1;
      cpu_halt <= 1'b0;
    end else begin
      osc_en <= (next_state != ST_STBY); // see R1 see R22
      wdt_clk_en <= (next_state != ST_STBY); // see R5
      chip_clk_en <= (next_state != ST_STBY) & (next_state != ST_SETTLE); // see R5 see R1
      cpu_halt <= (next_state != ST_RUN) & (next_state != ST_INIT); // see R23
    end
  end

  // pin state in standby: retained unless float select was set at entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_hold <= 1'b0;
      port_float <= 1'b0;
    end else if (state == ST_RUN && next_state == ST_STBY) begin
      port_hold <= ~standby_ctrl[`BIT_FLOAT]; // see R18
      port_float <= standby_ctrl[`BIT_FLOAT];
    end else if (next_state != ST_STBY && next_state != ST_SETTLE) begin
      port_hold <= 1'b0;
      port_float <= 1'b0;
    end
  end

  // ====================
  // module standby gates
  gate_if #(.N(32)) gif ();
  assign gif.stop_req = {module_stop_ctrl_b, module_stop_ctrl_a}; // see R24
  assign gif.bus_cycle_end = bus_cycle_end; // see R13 see R14

  // gates start stopped where the stop bits reset to one, not a bus cycle later
  module_gate #(
    .N(32),
    .STOP_INIT({`RST_STOP_B, `RST_STOP_A}) // see R16
  ) u_gate (
    .clk(clk),
    .arst_n(arst_n),
    .gif(gif),
    .chip_clk_en(chip_clk_en), // see R22
    .periph_clk_en(periph_clk_en),
    .periph_init(periph_init),
    .periph_acc_en(periph_acc_en)
  );

endmodule

// ### standby_params.svh
// constants of the standby power controller: offsets, resets, fields, bus answers
// guarded, so the package and every file that uses the macros may include it
`ifndef STANDBY_PARAMS_SVH
`define STANDBY_PARAMS_SVH
// ====================
// register byte offsets
`define OFS_STANDBY_CTRL 6'h00
`define OFS_EDGE_SELECT 6'h04
`define OFS_STOP_A 6'h08
`define OFS_STOP_B 6'h0c
`define OFS_STATUS 6'h10
`define OFS_COMMAND 6'h14
// ====================
// reset values
`define RST_STANDBY_CTRL 8'h00
`define RST_EDGE_SELECT 8'h55
`define RST_STOP_A 16'h003f
`define RST_STOP_B 16'hf0f0
// ====================
// standby_ctrl fields
`define BIT_DEEP 7
`define BIT_FLOAT 6
`define BIT_IRQ_WAKE 5
`define PERIOD_MSB 2
// command field: the sleep instruction
`define BIT_SLEEP 0
// ====================
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### standby_pkg.sv
// types shared by the standby power controller modules
// assumes the params header sits in the same folder
package standby_pkg;
`include "standby_params.svh"
  // gray along run, sleep, standby, settle; init sits one bit from settle, two from run
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SLEEP = 3'h1,
    ST_STBY = 3'h3,
    ST_SETTLE = 3'h2,
    ST_INIT = 3'h6
  } pwr_state_t;
  // per-pin wake edge choice
  typedef enum logic [1:0] {
    EDGE_LOW_LEVEL = 2'h0,
    EDGE_FALL = 2'h1,
    EDGE_RISE = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;
endpackage

// ### gate_if.sv
// interface carrying module stop requests to the per-module gates
// assumes one clock domain shared with the controller
interface gate_if #(parameter int N = 32);
  logic [N-1:0] stop_req;
  logic bus_cycle_end;
  logic [N-1:0] stopped;
  modport ctrl (output stop_req, output bus_cycle_end, input stopped);
  modport gate (input stop_req, input bus_cycle_end, output stopped);
endinterface

// ### module_gate.sv
// per-module clock gate, initialise request and register access block
// assumes bus_cycle_end pulses at the close of each peripheral bus cycle
module module_gate #(
  parameter int N = 32,
  parameter logic [N-1:0] STOP_INIT = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  gate_if.gate gif,
  input wire logic chip_clk_en,
  output logic [N-1:0] periph_clk_en,
  output logic [N-1:0] periph_init,
  output logic [N-1:0] periph_acc_en
);
  import standby_pkg::*;
  logic [N-1:0] eff_stop;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_mod
      // stop state changes only at a bus cycle boundary, never mid-access
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          eff_stop[i] <= STOP_INIT[i]; // see R16
        end else if (gif.bus_cycle_end) begin
          eff_stop[i] <= gif.stop_req[i]; // see R13 see R14
        end
      end
      // own gate per module so each is controlled alone
      assign periph_clk_en[i] = chip_clk_en & ~eff_stop[i]; // see R24
      assign periph_init[i] = eff_stop[i]; // see R15
      assign periph_acc_en[i] = ~eff_stop[i]; // see R17
    end
  endgenerate
  assign gif.stopped = eff_stop;
endmodule

// ### wake_detect.sv
// edge detector on the external interrupt pins for leaving standby
// assumes pins synchronous to clk; armed only while the clock is stopped
module wake_detect #(
  parameter int PINS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic armed,
  input wire logic enable,
  input wire logic [2*PINS-1:0] irq_edge_mode,
  input wire logic [PINS-1:0] irq_pin,
  output logic wake
);
  import standby_pkg::*;
  logic [PINS-1:0] prev;
  logic [PINS-1:0] hit;
  // previous pin level for edge compare
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= '1;
    end else begin
      prev <= irq_pin;
    end
  end
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      logic fall;
      logic rise;
      edge_mode_t m;
      assign m = edge_mode_t'(irq_edge_mode[2*i+1 -: 2]);
      assign fall = prev[i] & ~irq_pin[i];
      assign rise = ~prev[i] & irq_pin[i];
      // both-edge restarts on the fall only; low level never wakes
      assign hit[i] = ((m == EDGE_FALL || m == EDGE_BOTH) & fall) | // see R11
                      ((m == EDGE_RISE) & rise); // see R11
    end
  endgenerate
  // only with the wake enable set does an edge restart the oscillator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake <= 1'b0;
    end else begin
      wake <= armed & enable & (|hit); // see R4
    end
  end
endmodule

// ### standby_power_control_asserts.sv
// concurrent checks on the standby power controller ports
// assumes one clock domain and the design top module ports by name
module standby_power_control_asserts #(
  parameter int PINS = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hard_init_pin_n,
  input wire logic [PINS-1:0] irq_pin,
  input wire logic wdt_overflow,
  input wire logic bus_cycle_end,
  input wire logic s_axi_bvalid,
  input wire logic osc_en,
  input wire logic wdt_clk_en,
  input wire logic chip_clk_en,
  input wire logic cpu_halt,
  input wire logic cpu_reset_start,
  input wire logic irq_exc_start,
  input wire logic port_hold,
  input wire logic port_float,
  input wire logic [31:0] periph_clk_en,
  input wire logic [31:0] periph_init,
  input wire logic [31:0] periph_acc_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ====================
  // wake sequences
  sequence settling;
    osc_en && !chip_clk_en;
  endsequence
  // four quiet cycles leave no edge in flight, so the oscillator must stay off
  sequence quiet_standby;
    !osc_en && hard_init_pin_n && $stable(irq_pin);
  endsequence
  // ====================
  // properties
  chk_pin_clocks_all: assert property (!hard_init_pin_n |=> osc_en && chip_clk_en && !cpu_halt)
    else $error("reset pin did not clock the chip");
  chk_pin_release: assert property ($rose(hard_init_pin_n) |=> cpu_reset_start)
    else $error("no reset handling after pin release");
  chk_no_edge_wake: assert property (quiet_standby [*4] |=> !osc_en)
    else $error("oscillator started without a pin edge");
  chk_settle_wdt_only: assert property (settling |-> wdt_clk_en && cpu_halt && periph_clk_en == 32'h0)
    else $error("clock leaked during settling");
  chk_overflow_ends: assert property (settling ##0 wdt_overflow && hard_init_pin_n |=> chip_clk_en && !cpu_halt && irq_exc_start)
    else $error("overflow did not end settling");
  chk_stop_at_end: assert property ($changed(periph_init) |-> $past(bus_cycle_end))
    else $error("module gate moved outside a bus cycle end");
  chk_init_blocks: assert property (periph_init == ~periph_acc_en)
    else $error("stopped module not initialised or still accessible");
  chk_gate_each: assert property (periph_clk_en == (chip_clk_en ? periph_acc_en : 32'h0))
    else $error("module clock gate mismatch");
  chk_deep_stops: assert property (!osc_en |-> !chip_clk_en && !wdt_clk_en && cpu_halt && (port_hold != port_float))
    else $error("standby left something running");
  chk_halt_on_write: assert property ($rose(cpu_halt) |-> $rose(s_axi_bvalid))
    else $error("halt without a sleep write");
endmodule

bind standby_power_control standby_power_control_asserts #(.PINS(PINS)) u_chk (.*);

// ### wdt_partner.sv
// watchdog and peripheral bus model facing the controller
// assumes the controller clock; overflow counted only while settling
module wdt_partner (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wdt_clk_en,
  input wire logic chip_clk_en,
  input wire logic [2:0] watchdog_period_select,
  output logic wdt_overflow,
  output logic bus_cycle_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] settle_cnt;
  logic [1:0] phase;
  // overflow after (period+1)*8 settling cycles, longer than any start-up here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt <= 6'h00;
      wdt_overflow <= 1'b0;
    end else begin
      wdt_overflow <= !chip_clk_en && wdt_clk_en && settle_cnt == {watchdog_period_select, 3'h7};
      settle_cnt <= (!wdt_clk_en || chip_clk_en) ? 6'h00 : settle_cnt + 6'h01;
    end
  end
  // peripheral bus cycles close every fourth clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
      bus_cycle_end <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      bus_cycle_end <= (phase == 2'h3);
    end
  end
endmodule

// ### tb_standby_power_control.sv
// self-checking bench for the standby power controller
// assumes design, partner model and checker compiled beforehand
`include "standby_params.svh"
module tb_standby_power_control import standby_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hard_init_pin_n, cpu_irq, wdt_overflow;
  logic bus_cycle_end, osc_en, wdt_clk_en, chip_clk_en, cpu_halt, cpu_reset_start, irq_exc_start;
  logic port_hold, port_float;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, periph_clk_en, periph_init, periph_acc_en;
  logic [3:0] s_axi_wstrb, irq_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] watchdog_period_select;
  int mismatches = 0;
  int tests_run = 0;
  standby_power_control #(.PINS(4)) uut (.*);
  wdt_partner wdt (.*);
  // ====================
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // each half is released at its own handshake; response held until seen
  task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write_answer", n < 50, 1'b1);
  endtask
  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read_answer", n < 50, 1'b1);
  endtask
  // gates move only at a bus cycle end, so wait for one and let it land
  task automatic cyc_end();
    for (int n = 0; n < 8 && !bus_cycle_end; n++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  // ====================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axr(`OFS_STANDBY_CTRL, d, r);
    chk("standby_ctrl", d, `RST_STANDBY_CTRL);
    axr(`OFS_EDGE_SELECT, d, r);
    chk("edge_select", d, `RST_EDGE_SELECT);
    axr(`OFS_STOP_A, d, r);
    chk("stop_a", d, `RST_STOP_A);
    axr(`OFS_STOP_B, d, r);
    chk("stop_b", d, `RST_STOP_B);
    axr(6'h18, d, r);
    chk("unmapped", r, `RESP_SLVERR);
    axw(`OFS_STATUS, 32'h7, r);
    chk("status_ro", r, `RESP_SLVERR);
    chk("acc_reset", periph_acc_en, ~{`RST_STOP_B, `RST_STOP_A});
  endtask
  task automatic t_stop();
    logic [1:0] r;
    axw(`OFS_STOP_A, 32'h1, r); // no module interrupts pending; bench is the only master
    cyc_end();
    chk("acc_on", periph_acc_en[15:0], 16'hfffe);
    chk("clk_on", periph_clk_en[15:0], 16'hfffe);
    axw(`OFS_STOP_A, 32'h3, r);
    cyc_end();
    chk("init", periph_init[15:0], 16'h0003);
    chk("acc_off", periph_acc_en[15:0], 16'hfffc);
  endtask
  task automatic t_sleep();
    logic [1:0] r;
    axw(`OFS_STANDBY_CTRL, 32'h0, r);
    axw(`OFS_COMMAND, 32'h1, r);
    chk("sleep", {cpu_halt, osc_en, chip_clk_en}, 3'b111);
    cpu_irq <= 1'b1; // no register access while asleep
    @(posedge clk);
    cpu_irq <= 1'b0;
    repeat (2) @(posedge clk);
    chk("sleep_end", cpu_halt, 1'b0);
  endtask
  task automatic t_wake(input edge_mode_t m, input logic en, input logic wake);
    logic [1:0] r;
    logic [31:0] d;
    int n;
    // pin rests opposite the wake edge; other pins stay in the ignored mode
    irq_pin <= {3'h0, m != EDGE_RISE};
    axw(`OFS_EDGE_SELECT, {30'h0, m}, r);
    // the both-edge run also selects floating ports
    axw(`OFS_STANDBY_CTRL, {24'h0, 1'b1, m == EDGE_BOTH, en, 5'h01}, r);
    axw(`OFS_COMMAND, 32'h1, r);
    repeat (2) @(posedge clk);
    chk("osc_off", osc_en, 1'b0);
    chk("hold", {port_hold, port_float}, {m != EDGE_BOTH, m == EDGE_BOTH});
    axr(`OFS_STATUS, d, r);
    chk("status_stby", d, {29'h0, ST_STBY});
    irq_pin[0] <= ~irq_pin[0];
    for (n = 0; n < 20 && !osc_en; n++) @(posedge clk);
    chk("woke", osc_en, wake);
    if (wake) begin
      chk("settle", {wdt_clk_en, chip_clk_en}, 2'b10);
      for (n = 0; n < 300 && !chip_clk_en; n++) @(posedge clk);
      chk("irq_exc", {irq_exc_start, cpu_halt}, 2'b10);
    end else begin
      hard_init_pin_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("pin_wake", {osc_en, chip_clk_en, cpu_halt}, 3'b110);
      hard_init_pin_n <= 1'b1;
      for (n = 0; n < 10 && !cpu_reset_start; n++) @(posedge clk);
      chk("rst_exc", cpu_reset_start, 1'b1);
    end
  endtask
  // ====================
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cpu_irq, arst_n} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_pin} = '0;
    s_axi_wstrb = 4'hf;
    hard_init_pin_n = 1'b1;
    repeat (10) @(posedge clk);
    chk("acc_in_reset", periph_acc_en, ~{`RST_STOP_B, `RST_STOP_A});
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_regs();
    t_stop();
    t_sleep();
    t_wake(EDGE_FALL, 1'b1, 1'b1);
    t_wake(EDGE_RISE, 1'b1, 1'b1);
    t_wake(EDGE_BOTH, 1'b1, 1'b1);
    t_wake(EDGE_FALL, 1'b0, 1'b0);
    t_wake(EDGE_LOW_LEVEL, 1'b1, 1'b0);
    stop_test();
  end
  // hang guard, well past the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test();
  end
endmodule
